/* File: ocs_pkg.sv */
// constants, mode codes and carrier types of the oscillator mode clock select
// What this block does
// - resistor-cap mode drives quarter-rate clock out
// - resistor-cap io mode frees pin as port bit
// - external clock modes switch feedback amplifier off
// - external clock modes skip oscillator start-up wait
// - external clock mode drives quarter-rate clock out
// - external clock io mode frees pin as port
// - multiplied mode makes four ticks per input cycle
// - multiplier enabled only in high-speed multiplied mode
// - mode field is three bits, fixed at programming
// - lock timer holds execution until time-out expires
// - three bits decode to exactly one mode
// - lock time-out sized at about two milliseconds
package ocs_pkg;

   // ****************************************************************
   // mode codes
   // ****************************************************************
   localparam int MODE_W = 3;

   typedef enum logic [MODE_W-1:0] {
      low_power_crystal_mode     = 3'h0,
      standard_crystal_mode      = 3'h1,
      high_speed_crystal_mode    = 3'h2,
      high_speed_multiplied_mode = 3'h3,
      resistor_cap_mode          = 3'h4,
      resistor_cap_io_mode       = 3'h5,
      ext_clock_mode             = 3'h6,
      ext_clock_io_mode          = 3'h7
   } ocs_mode_e;

   // mode latched before reset release settles on the slowest crystal
   localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_SYS_MHZ = 200;
   localparam int PLL_LOCK_TIME_US = 2000;
   localparam int PLL_LOCK_CYCLES = PLL_LOCK_TIME_US * CLK_SYS_MHZ;
   localparam int LOCK_CNT_W = 20;
   // start-up wait in rising edges of the oscillator input
   localparam int OST_EDGES = 1024;
   localparam int OST_CNT_W = 11;
   // input period measurement of the multiplier, saturating
   localparam int PERIOD_W = 16;
   localparam int MULT_FACTOR = 4;
   localparam int QUARTER_DIV = 4;
   localparam int QUARTER_CNT_W = 2;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic out;
      logic oe;
   } ocs_pin_s;

   typedef struct packed {
      logic exec_hold;
      logic pll_en;
      logic pll_locked;
      logic feedback_amp_en;
      logic startup_wait;
      logic sleeping;
      logic [MODE_W-1:0] mode;
   } ocs_status_s;

   localparam ocs_pin_s PIN_RESET = '{out: 1'b0, oe: 1'b0};

endpackage : ocs_pkg

/* File: ocs_quarter_div.sv */
// modulo-four divider stepped by rising edges of the oscillator input
`timescale 1ns/1ps
`default_nettype none
module ocs_quarter_div (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_osc_rise,
   output logic o_quarter_clk
);
   import ocs_pkg::*;

   logic [QUARTER_CNT_W-1:0] phase;

   // free-running modulo four
   // wraps on its own so the output never carries a short pulse
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         phase <= '0;
      end else if (i_osc_rise) begin
         phase <= phase + 2'h1;
      end
   end

   // msb of the phase is high for two input cycles of four
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_quarter_clk <= 1'b0;
      end else begin
         o_quarter_clk <= phase[QUARTER_CNT_W-1];
      end
   end

endmodule : ocs_quarter_div
`default_nettype wire

/* File: ocs_pll_mult.sv */
// times-four tick generator locked to the oscillator input period
`timescale 1ns/1ps
`default_nettype none
module ocs_pll_mult (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_enable,
   input wire logic i_osc_rise,
   output logic o_tick
);
   import ocs_pkg::*;

   logic [PERIOD_W-1:0] period_cnt;
   logic [PERIOD_W-1:0] quarter;
   logic [PERIOD_W-1:0] phase_cnt;
   logic [1:0] extra_left;

   // measure system cycles between input edges, saturating
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         period_cnt <= '0;
         quarter <= '0;
      end else if (!i_enable) begin
         period_cnt <= '0;
         quarter <= '0;
      end else if (i_osc_rise) begin
         period_cnt <= 16'h0001;
         quarter <= period_cnt >> 2;
      end else if (period_cnt != 16'hffff) begin
         period_cnt <= period_cnt + 16'h0001;
      end
   end

   // one tick on the edge, three more spaced a quarter apart
   // limitation: the spacing follows the previous period, one behind
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         phase_cnt <= '0;
         extra_left <= 2'h0;
         o_tick <= 1'b0;
      end else if (!i_enable) begin
         phase_cnt <= '0;
         extra_left <= 2'h0;
         o_tick <= 1'b0;
      end else if (i_osc_rise) begin
         phase_cnt <= 16'h0001;
         extra_left <= 2'(MULT_FACTOR - 1);
         o_tick <= 1'b1;
      end else if (extra_left != 2'h0 && quarter != '0 &&
                   phase_cnt >= quarter) begin
         phase_cnt <= 16'h0001;
         extra_left <= extra_left - 2'h1;
         o_tick <= 1'b1;
      end else begin
         phase_cnt <= phase_cnt + 16'h0001;
         o_tick <= 1'b0;
      end
   end

endmodule : ocs_pll_mult
`default_nettype wire

/* File: ocs_clock_select.sv */
// top of the oscillator mode clock select: decode, start-up, pin mux
`timescale 1ns/1ps
`default_nettype none
module ocs_clock_select #(
   parameter int unsigned PLL_LOCK_CYC = ocs_pkg::PLL_LOCK_CYCLES
) (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic [ocs_pkg::MODE_W-1:0] i_osc_mode_select_field,
   input wire logic i_osc_input_pin,
   input wire logic i_osc_output_pin_in,
   input wire logic i_port_bit_six_out,
   input wire logic i_port_bit_six_oe,
   input wire logic i_sleep_req,
   input wire logic i_wake_req,
   output ocs_pkg::ocs_pin_s o_osc_output_pin,
   output logic o_first_port_bit_six_in,
   output logic o_sys_tick,
   output ocs_pkg::ocs_status_s o_status
);
   import ocs_pkg::*;

   // ****************************************************************
   // declarations
   // ****************************************************************
   typedef enum logic [4:0] {
      ST_CAPTURE  = 5'h01,
      ST_OST      = 5'h02,
      ST_PLL_LOCK = 5'h04,
      ST_RUN      = 5'h08,
      ST_SLEEP    = 5'h10
   } ocs_state_e;

   ocs_state_e state;
   ocs_state_e next_state;
   ocs_mode_e mode;
   logic captured;
   logic osc_meta;
   logic osc_sync;
   logic osc_prev;
   logic osc_rise;
   logic pin2_meta;
   logic pin2_sync;
   logic is_crystal;
   logic is_pll;
   logic is_rc;
   logic is_ext;
   logic is_io;
   logic drives_quarter;
   logic [OST_CNT_W-1:0] ost_cnt;
   logic ost_done;
   logic [LOCK_CNT_W-1:0] lock_cnt;
   logic lock_done;
   logic quarter_clk;
   logic pll_tick;
   logic pll_active;
   logic wake_seen;

   localparam logic [OST_CNT_W-1:0] OST_LAST = OST_CNT_W'(OST_EDGES - 1);
   localparam logic [LOCK_CNT_W-1:0] LOCK_ONE = 20'h00001;

   // ****************************************************************
   // input synchronisers
   // ****************************************************************

   // oscillator input is asynchronous to the system clock
   // reset to the stopped pin's high rest level, so no false rise follows
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         osc_meta <= 1'b1;
         osc_sync <= 1'b1;
         osc_prev <= 1'b1;
      end else begin
         osc_meta <= i_osc_input_pin;
         osc_sync <= osc_meta;
         osc_prev <= osc_sync;
      end
   end

   // every oscillator edge comes from the pin in the external modes
   // crystal modes take a driven clock on the same path
   assign osc_rise = osc_sync & ~osc_prev;

   // port bit six read back through its own synchroniser
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         pin2_meta <= 1'b0;
         pin2_sync <= 1'b0;
      end else begin
         pin2_meta <= i_osc_output_pin_in;
         pin2_sync <= pin2_meta;
      end
   end

   // ****************************************************************
   // mode capture and decode
   // ****************************************************************

   // field taken once after reset release, never again
   // the field is a programmed setting, so run-time changes are ignored
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         mode <= ocs_mode_e'(MODE_RESET);
         captured <= 1'b0;
      end else if (!captured) begin
         mode <= ocs_mode_e'(i_osc_mode_select_field);
         captured <= 1'b1;
      end
   end

   // each code selects exactly one of eight modes
   always_comb begin
      is_crystal = 1'b0;
      is_pll = 1'b0;
      is_rc = 1'b0;
      is_ext = 1'b0;
      is_io = 1'b0;
      unique case (mode)
         low_power_crystal_mode: begin
            is_crystal = 1'b1;
         end
         standard_crystal_mode: begin
            is_crystal = 1'b1;
         end
         high_speed_crystal_mode: begin
            is_crystal = 1'b1;
         end
         high_speed_multiplied_mode: begin
            is_crystal = 1'b1;
            is_pll = 1'b1;
         end
         resistor_cap_mode: begin
            is_rc = 1'b1;
         end
         resistor_cap_io_mode: begin
            is_rc = 1'b1;
            is_io = 1'b1;
         end
         ext_clock_mode: begin
            is_ext = 1'b1;
         end
         ext_clock_io_mode: begin
            is_ext = 1'b1;
            is_io = 1'b1;
         end
      endcase
   end

   // resistor-cap mode drives the quarter clock
   // external clock mode drives the quarter clock
   assign drives_quarter = (is_rc | is_ext) & ~is_io;

   // ****************************************************************
   // start-up sequencing
   // ****************************************************************

   // wake request acts as a level; a pulse must meet a sleeping edge
   assign wake_seen = i_wake_req;

   assign ost_done = (ost_cnt == OST_LAST) && osc_rise;
   assign lock_done = (lock_cnt == LOCK_CNT_W'(PLL_LOCK_CYC - 1));

   always_comb begin
      next_state = state;
      unique case (state)
         ST_CAPTURE: begin
            // no start-up wait outside the crystal modes
            if (captured) begin
               next_state = is_crystal ? ST_OST : ST_RUN;
            end
         end
         ST_OST: begin
            if (ost_done) begin
               next_state = is_pll ? ST_PLL_LOCK : ST_RUN;
            end
         end
         ST_PLL_LOCK: begin
            // execution stays held until the lock time-out
            if (lock_done) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (i_sleep_req) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            // recovery in the external modes resumes at once
            if (wake_seen) begin
               next_state = is_crystal ? ST_OST : ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= ST_CAPTURE;
      end else begin
         state <= next_state;
      end
   end

   // start-up wait counts oscillator edges, not system cycles
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ost_cnt <= '0;
      end else if (state != ST_OST) begin
         ost_cnt <= '0;
      end else if (osc_rise && ost_cnt != OST_LAST) begin
         ost_cnt <= ost_cnt + 11'h001;
      end
   end

   // lock timer counts the two millisecond time-out
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         lock_cnt <= '0;
      end else if (state != ST_PLL_LOCK) begin
         lock_cnt <= '0;
      end else if (!lock_done) begin
         lock_cnt <= lock_cnt + LOCK_ONE;
      end
   end

   // ****************************************************************
   // quarter clock and multiplier
   // ****************************************************************

   // divider keeps running in every mode; only the pin mux uses it
   ocs_quarter_div u_quarter_div (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_osc_rise(osc_rise),
      .o_quarter_clk(quarter_clk)
   );

   // multiplier runs only in high-speed multiplied mode
   assign pll_active = is_pll && captured && (state != ST_SLEEP);

   ocs_pll_mult u_pll_mult (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_enable(pll_active),
      .i_osc_rise(osc_rise),
      .o_tick(pll_tick)
   );

   // system tick is four per input cycle with the multiplier
   // otherwise the tick is the oscillator input edge itself
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_sys_tick <= 1'b0;
      end else if (state != ST_RUN) begin
         o_sys_tick <= 1'b0;
      end else if (is_pll) begin
         o_sys_tick <= pll_tick;
      end else begin
         o_sys_tick <= osc_rise;
      end
   end

   // ****************************************************************
   // output pin mux
   // ****************************************************************

   // crystal modes leave the pin to the analog amplifier, so oe stays low
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_osc_output_pin <= PIN_RESET;
      end else if (!captured || is_crystal) begin
         o_osc_output_pin <= PIN_RESET;
      end else if (is_io) begin
         // resistor-cap io mode hands the pin to the port
         // external clock io mode hands the pin to the port
         o_osc_output_pin.out <= i_port_bit_six_out;
         o_osc_output_pin.oe <= i_port_bit_six_oe;
      end else if (state == ST_SLEEP) begin
         // stopped oscillator: the pin is held low
         o_osc_output_pin.out <= 1'b0;
         o_osc_output_pin.oe <= 1'b1;
      end else if (drives_quarter) begin
         // quarter clock in resistor-cap and external clock modes
         o_osc_output_pin.out <= quarter_clk;
         o_osc_output_pin.oe <= 1'b1;
      end else begin
         o_osc_output_pin <= PIN_RESET;
      end
   end

   // port read value only meaningful in the io modes
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_first_port_bit_six_in <= 1'b0;
      end else if (captured && is_io) begin
         o_first_port_bit_six_in <= pin2_sync;
      end else begin
         o_first_port_bit_six_in <= 1'b0;
      end
   end

   // ****************************************************************
   // status
   // ****************************************************************

   // amplifier off in the external clock modes to save current
   // resistor-cap modes use no amplifier either; sleep turns it off
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_status <= '0;
         o_status.exec_hold <= 1'b1;
      end else begin
         // hold until the run state is reached
         o_status.exec_hold <= (next_state != ST_RUN);
         o_status.pll_en <= pll_active;
         o_status.pll_locked <= is_pll && (next_state == ST_RUN);
         o_status.feedback_amp_en <= captured && is_crystal &&
                                     (next_state != ST_SLEEP);
         // lock wait shows as pll_en without pll_locked, not here
         o_status.startup_wait <= (next_state == ST_OST);
         o_status.sleeping <= (next_state == ST_SLEEP);
         o_status.mode <= mode;
      end
   end

endmodule : ocs_clock_select
`default_nettype wire

/* File: ocs_clock_select_properties.sv */
// port-level checks of the oscillator mode clock select
`timescale 1ns/1ps
`default_nettype none
module ocs_clock_select_properties
   import ocs_pkg::*;
#(
   parameter int unsigned PLL_LOCK_CYC = 50
) (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_port_bit_six_out,
   input wire logic i_port_bit_six_oe,
   input wire ocs_pkg::ocs_pin_s o_osc_output_pin,
   input wire logic o_first_port_bit_six_in,
   input wire logic o_sys_tick,
   input wire ocs_pkg::ocs_status_s o_status
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   // ****************************************************************
   // helpers
   // ****************************************************************
   logic ext;
   logic io;
   int unsigned lock_cnt;
   assign ext = (o_status.mode[2:1] == 2'b11);
   assign io = (o_status.mode == 3'h5) || (o_status.mode == 3'h7);
   // cycles spent waiting for lock, cleared whenever the wait ends
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         lock_cnt <= 0;
      end else if (o_status.pll_en && !o_status.startup_wait &&
                   !o_status.pll_locked) begin
         lock_cnt <= lock_cnt + 1;
      end else begin
         lock_cnt <= 0;
      end
   end
   // ****************************************************************
   // assertions
   // ****************************************************************
   property p_pll_only_hs;
      o_status.pll_en |-> o_status.mode == 3'h3;
   endproperty
   a_pll_only_hs: assert property (p_pll_only_hs)
      else $error("multiplier enabled outside multiplied mode");
   property p_amp_off_ext;
      ext |-> !o_status.feedback_amp_en;
   endproperty
   a_amp_off_ext: assert property (p_amp_off_ext)
      else $error("feedback amplifier on in external clock mode");
   property p_no_wait_ext;
      ext |-> !o_status.startup_wait;
   endproperty
   a_no_wait_ext: assert property (p_no_wait_ext)
      else $error("start-up wait in external clock mode");
   property p_quarter_drive;
      !o_status.exec_hold && (o_status.mode == 3'h4 ||
         o_status.mode == 3'h6) |-> o_osc_output_pin.oe;
   endproperty
   a_quarter_drive: assert property (p_quarter_drive)
      else $error("quarter clock pin not driven");
   property p_io_mirror;
      io ##1 io && $stable(i_port_bit_six_out) && $stable(i_port_bit_six_oe)
         |-> o_osc_output_pin == {i_port_bit_six_out, i_port_bit_six_oe};
   endproperty
   a_io_mirror: assert property (p_io_mirror)
      else $error("output pin does not follow port bit six");
   property p_bit6_idle;
      !io |-> o_first_port_bit_six_in == 1'b0;
   endproperty
   a_bit6_idle: assert property (p_bit6_idle)
      else $error("port bit six read outside io modes");
   property p_mode_fixed;
      !o_status.exec_hold |=> $stable(o_status.mode);
   endproperty
   a_mode_fixed: assert property (p_mode_fixed)
      else $error("mode changed after capture");
   property p_hold_unlocked;
      o_status.pll_en && !o_status.pll_locked |-> o_status.exec_hold;
   endproperty
   a_hold_unlocked: assert property (p_hold_unlocked)
      else $error("execution released before lock");
   property p_lock_time;
      $rose(o_status.pll_locked) |->
         lock_cnt + 3 >= PLL_LOCK_CYC && lock_cnt <= PLL_LOCK_CYC + 2;
   endproperty
   a_lock_time: assert property (p_lock_time)
      else $error("lock time-out of wrong length");
   property p_no_tick_wait;
      o_status.startup_wait |-> !o_sys_tick;
   endproperty
   a_no_tick_wait: assert property (p_no_tick_wait)
      else $error("tick during start-up wait");
   property p_tick_direct;
      o_sys_tick && !o_status.pll_en |=> !o_sys_tick [*4];
   endproperty
   a_tick_direct: assert property (p_tick_direct)
      else $error("ticks too close without multiplier");
endmodule : ocs_clock_select_properties
`default_nettype wire

/* File: ocs_osc_source.sv */
// behavioural crystal, rc network or clock driver on the input pin
`timescale 1ns/1ps
`default_nettype none
module ocs_osc_source #(
   parameter int HALF_NS = 21
) (
   input wire logic i_run,
   output logic o_pin
);
   // ****************************************************************
   // waveform
   // ****************************************************************
   initial o_pin = 1'b1;
   always begin
      if (i_run === 1'b1) begin
         #(HALF_NS);
         o_pin = ~o_pin;
      end else begin
         // stopped source: pin rests at the pull-up level
         o_pin = 1'b1;
         @(posedge i_run);
      end
   end
endmodule : ocs_osc_source
`default_nettype wire

/* File: ocs_clock_select_tb.sv */
// self-checking bench of the oscillator mode clock select
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
   $display("mismatch t=%0t act=%h exp=%h", $time, (a), (e)); end end
module ocs_clock_select_tb;
   import ocs_pkg::*;
   localparam int unsigned LOCK_CYC = 50;
   typedef struct {
      int k;
      logic [15:0] v;
   } ocs_note_s;
   logic i_clk_sys, i_resetn, osc_run, osc_pin, pin_in;
   logic p6_out, p6_oe, sleep_req, wake_req, bit6, tick;
   logic [MODE_W-1:0] mode_sel;
   ocs_pin_s pin;
   ocs_status_s st;
   int err_count, n_checks, n_tick, n_qrise;
   ocs_note_s q[$];
   ocs_note_s nt;
   // ****************************************************************
   // instances and clock
   // ****************************************************************
   ocs_osc_source ocs_osc_source_i (.i_run(osc_run), .o_pin(osc_pin));
   ocs_clock_select #(.PLL_LOCK_CYC(LOCK_CYC)) ocs_clock_select_i (
      .i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
      .i_osc_mode_select_field(mode_sel), .i_osc_input_pin(osc_pin),
      .i_osc_output_pin_in(pin_in), .i_port_bit_six_out(p6_out),
      .i_port_bit_six_oe(p6_oe), .i_sleep_req(sleep_req),
      .i_wake_req(wake_req), .o_osc_output_pin(pin),
      .o_first_port_bit_six_in(bit6), .o_sys_tick(tick), .o_status(st));
   initial begin
      i_clk_sys = 1'b0;
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) if (tick === 1'b1) n_tick++;
   always @(posedge pin.out) n_qrise++;
   // ****************************************************************
   // notes and the watcher that settles them
   // ****************************************************************
   function automatic logic [15:0] obs(input int k);
      case (k)
         0: obs = 16'(st);
         1: obs = 16'(pin);
         2: obs = 16'(bit6);
         3: obs = 16'(n_tick);
         4: obs = 16'(n_qrise);
         default: obs = 16'({st.sleeping, st.startup_wait});
      endcase
   endfunction : obs
   task automatic note(input int k, input logic [15:0] v);
      q.push_back('{k, v});
   endtask : note
   initial begin
      forever begin
         wait (q.size() > 0);
         nt = q.pop_front();
         `CHK(obs(nt.k), nt.v)
      end
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   // ****************************************************************
   // sequences
   // ****************************************************************
   task automatic start(input int m);
      @(negedge i_clk_sys);
      i_resetn = 1'b0;
      mode_sel = 3'(m);
      osc_run = 1'b1;
      repeat (6) @(negedge i_clk_sys);
      i_resetn = 1'b1;
   endtask : start
   task automatic wait_run;
      int i;
      i = 0;
      while (st.exec_hold !== 1'b0 && i < 20000) begin
         @(negedge i_clk_sys);
         i++;
      end
   endtask : wait_run
   // 20 input periods are a whole number of system cycles, so counts are exact
   task automatic count_window;
      @(posedge osc_pin);
      #1;
      n_tick = 0;
      n_qrise = 0;
      repeat (20) @(posedge osc_pin);
      #1;
   endtask : count_window
   task automatic io_check(input int m);
      int i;
      for (i = 0; i < 4; i++) begin
         @(negedge i_clk_sys);
         p6_out = 1'($urandom);
         p6_oe = 1'($urandom);
         pin_in = 1'($urandom);
         repeat (4) @(negedge i_clk_sys);
         if (m == 5 || m == 7) begin
            note(1, 16'({p6_out, p6_oe}));
            note(2, 16'(pin_in));
         end else begin
            note(2, 16'h0);
            if (m < 4) note(1, 16'h0);
         end
      end
   endtask : io_check
   task automatic sleep_wake(input int m, input ocs_status_s ex);
      @(negedge i_clk_sys);
      sleep_req = 1'b1;
      @(negedge i_clk_sys);
      sleep_req = 1'b0;
      osc_run = 1'b0;
      repeat (2) @(negedge i_clk_sys);
      note(5, 16'h2);
      if (m == 4 || m == 6) note(1, 16'h1);
      osc_run = 1'b1;
      @(negedge i_clk_sys);
      wake_req = 1'b1;
      @(negedge i_clk_sys);
      wake_req = 1'b0;
      note(5, (m < 4) ? 16'h1 : 16'h0);
      wait_run();
      note(0, 16'(ex));
   endtask : sleep_wake
   initial begin
      int m;
      ocs_status_s ex;
      i_resetn = 1'b0;
      mode_sel = '0;
      osc_run = 1'b0;
      pin_in = 1'b0;
      p6_out = 1'b0;
      p6_oe = 1'b0;
      sleep_req = 1'b0;
      wake_req = 1'b0;
      void'($urandom(32'he9a0));
      for (m = 0; m < 8; m++) begin
         start(m);
         repeat (3) @(negedge i_clk_sys);
         // captured code must not follow later changes
         mode_sel = 3'($urandom);
         note(5, (m < 4) ? 16'h1 : 16'h0);
         wait_run();
         ex = '{exec_hold: 1'b0, pll_en: m == 3, pll_locked: m == 3,
                feedback_amp_en: m < 4, startup_wait: 1'b0,
                sleeping: 1'b0, mode: 3'(m)};
         note(0, 16'(ex));
         count_window();
         note(3, (m == 3) ? 16'd80 : 16'd20);
         if (m == 4 || m == 6) note(4, 16'd5);
         io_check(m);
         if (m >= 3) sleep_wake(m, ex);
      end
      @(negedge i_clk_sys);
      give_verdict();
   end
   // hang guard: about twice the expected run length
   initial begin
      #450000;
      err_count++;
      give_verdict();
   end
endmodule : ocs_clock_select_tb
bind ocs_clock_select ocs_clock_select_properties #(
   .PLL_LOCK_CYC(PLL_LOCK_CYC)
) ocs_clock_select_properties_i (
   .i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
   .i_port_bit_six_out(i_port_bit_six_out),
   .i_port_bit_six_oe(i_port_bit_six_oe),
   .o_osc_output_pin(o_osc_output_pin),
   .o_first_port_bit_six_in(o_first_port_bit_six_in),
   .o_sys_tick(o_sys_tick), .o_status(o_status));
`default_nettype wire
